// *** core/lacq_acquisition.sv ***
// What this block does
// RULE_01 - samples eighteen channel inputs from the target on every acquisition
// RULE_02 - sample clock may come from an external target signal
// RULE_03 - asynchronous mode uses an internal sample clock at a programmed rate
// RULE_04 - external mode captures channels only on external clock edges
// RULE_05 - every channel sample is stored as one bit, high or low
// RULE_06 - samples fill memory as a ring, newest overwrite oldest before trigger
// RULE_07 - trigger position choice sets pre, post or mixed data kept
// RULE_08 - qualifier false blocks samples from being stored
// RULE_09 - a don't-care channel matches any value
// RULE_10 - trigger on rising or falling transitions of a channel
// RULE_11 - conditions: one-channel edge, level combination, count of clock cycles
// RULE_12 - acquisition memory contents can be read out by the host
// RULE_13 - user should pick a sample rate faster than signal changes
// RULE_14 - per channel: high, low, rise, fall, either edge, don't care
// RULE_15 - after trigger keep storing until post fill count, then stop
// RULE_16 - memory address of the trigger sample is recorded
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module lacq_acquisition (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic                          ce,
   input  wire logic                          extClk,
   input  wire logic [lacq_pkg::NUM_CHAN-1:0] chanPin,
   input  wire logic                          qualPin,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output var  logic                          hreadyout,
   output var  logic [31:0]                   hrdata,
   output var  logic                          hresp
);
   localparam int NC = lacq_pkg::NUM_CHAN;
   localparam int AW = lacq_pkg::ADDR_W;

   lacq_pkg::lacq_state_type state_q;
   lacq_pkg::lacq_fill_type  fill_q;
   logic                     syncMode_q;
   logic                     qualEn_q;
   logic [15:0]              rate_q;
   logic [15:0]              postFill_q;
   logic [15:0]              cycles_q;
   logic [lacq_pkg::PAT_W-1:0] pat_q;
   logic [15:0]              divCnt_q;
   logic [AW-1:0]            wrPtr_q;
   logic [AW-1:0]            trigAddr_q;
   logic [AW-1:0]            rdAddr_q;
   logic [15:0]              postCnt_q;
   logic [15:0]              sampleCnt_q;
   logic                     wrap_q;
   logic [NC-1:0]            prevWord_q;
   logic [NC-1:0]            rdData_q;
   logic [NC-1:0]            chanMeta_q;
   logic [NC-1:0]            chanSync_q;
   logic                     qualMeta_q;
   logic                     qualSync_q;
   logic                     reqMeta_q;
   logic                     reqSync_q;
   logic                     ackT_q;
   logic [NC:0]              held_q;
   logic                     reqT_q;
   logic                     ackMeta_q;
   logic                     ackSync_q;
   logic                     pend_q;
   logic                     pendWrite_q;
   logic [7:0]               pendAddr_q;
   logic [NC-1:0]            mem [lacq_pkg::DEPTH];

   logic                     accept;
   logic                     wrEn;
   logic                     rdDone;
   logic                     startReq;
   logic                     stopReq;
   logic                     sampleValid;
   logic                     sampleQual;
   logic [NC-1:0]            sampleWord;
   logic                     running;
   logic                     memWe;
   logic                     trigger;
   logic [15:0]              postTarget;
   logic [31:0]              readMux;

   lacq_match_if mif ();

   // ==========================================================
   // bus slave: one wait state on every transfer
   assign accept = hsel && htrans[lacq_pkg::HTRANS_ACTIVE] && hready;
   assign wrEn   = ce && pend_q && pendWrite_q;
   assign rdDone = ce && pend_q && !pendWrite_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pend_q      <= 1'b0;
         pendWrite_q <= 1'b0;
         pendAddr_q  <= 8'h00;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else if (ce) begin
         hresp <= 1'b0;
         if (pend_q) begin
            pend_q    <= 1'b0;
            hreadyout <= 1'b1;
         end else if (accept) begin
            pend_q      <= 1'b1;
            pendWrite_q <= hwrite;
            pendAddr_q  <= haddr[7:0];
            hreadyout   <= 1'b0;
         end
      end
   end

   always_comb begin
      readMux = 32'h0000_0000;
      unique case (pendAddr_q)
         lacq_pkg::REG_CTRL: begin
            readMux[lacq_pkg::CTRL_SYNC]                         = syncMode_q;
            readMux[lacq_pkg::CTRL_QUAL_EN]                      = qualEn_q;
            readMux[lacq_pkg::CTRL_FILL_LSB +: 2]                = fill_q;
         end
         lacq_pkg::REG_STATUS: begin
            readMux[lacq_pkg::STAT_RUN]  = running;
            readMux[lacq_pkg::STAT_POST] = state_q == lacq_pkg::ST_POST;
            readMux[lacq_pkg::STAT_DONE] = state_q == lacq_pkg::ST_DONE;
            readMux[lacq_pkg::STAT_WRAP] = wrap_q;
         end
         lacq_pkg::REG_RATE:      readMux[15:0] = rate_q;
         lacq_pkg::REG_POSTFILL:  readMux[15:0] = postFill_q;
         lacq_pkg::REG_PAT_LO:    readMux[lacq_pkg::PAT_LO_W-1:0] = pat_q[lacq_pkg::PAT_LO_W-1:0];
         lacq_pkg::REG_PAT_HI:    readMux[lacq_pkg::PAT_HI_W-1:0] = pat_q[lacq_pkg::PAT_W-1:lacq_pkg::PAT_LO_W];
         lacq_pkg::REG_CYCLES:    readMux[15:0] = cycles_q;
         lacq_pkg::REG_TRIG_ADDR: readMux[AW-1:0] = trigAddr_q;  // see RULE_16
         lacq_pkg::REG_WR_PTR:    readMux[AW-1:0] = wrPtr_q;
         lacq_pkg::REG_RD_ADDR:   readMux[AW-1:0] = rdAddr_q;
         lacq_pkg::REG_RD_DATA:   readMux[NC-1:0] = rdData_q;    // see RULE_12
         default:                 readMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (rdDone) begin
         hrdata <= readMux;
      end
   end

   // ==========================================================
   // configuration registers
   assign startReq = wrEn && pendAddr_q == lacq_pkg::REG_CTRL && hwdata[lacq_pkg::CTRL_START];
   assign stopReq  = wrEn && pendAddr_q == lacq_pkg::REG_CTRL && hwdata[lacq_pkg::CTRL_STOP];

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         syncMode_q <= 1'b0;
         qualEn_q   <= 1'b0;
         fill_q     <= lacq_pkg::FILL_PRE;
         rate_q     <= lacq_pkg::RATE_RST;
         postFill_q <= lacq_pkg::POSTFILL_RST;
         cycles_q   <= lacq_pkg::CYCLES_RST;
         pat_q      <= '0;
      end else if (wrEn) begin
         unique case (pendAddr_q)
            lacq_pkg::REG_CTRL: begin
               syncMode_q <= hwdata[lacq_pkg::CTRL_SYNC];
               qualEn_q   <= hwdata[lacq_pkg::CTRL_QUAL_EN];
               fill_q     <= lacq_pkg::lacq_fill_type'(hwdata[lacq_pkg::CTRL_FILL_LSB +: 2]);
            end
            lacq_pkg::REG_RATE:     rate_q     <= hwdata[15:0];
            lacq_pkg::REG_POSTFILL: postFill_q <= hwdata[15:0];
            lacq_pkg::REG_CYCLES:   cycles_q   <= hwdata[15:0];
            lacq_pkg::REG_PAT_LO:   pat_q[lacq_pkg::PAT_LO_W-1:0] <= hwdata[lacq_pkg::PAT_LO_W-1:0];
            lacq_pkg::REG_PAT_HI:   pat_q[lacq_pkg::PAT_W-1:lacq_pkg::PAT_LO_W] <= hwdata[lacq_pkg::PAT_HI_W-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // external clock domain: capture and hand over by toggle
   always_ff @(posedge extClk or posedge rst) begin
      if (rst) begin
         held_q    <= '0;
         reqT_q    <= 1'b0;
         ackMeta_q <= 1'b0;
         ackSync_q <= 1'b0;
      end else begin
         ackMeta_q <= ackT_q;
         ackSync_q <= ackMeta_q;
         if (reqT_q == ackSync_q) begin
            held_q <= {qualPin, chanPin};                   // see RULE_04
            reqT_q <= !reqT_q;
         end
      end
   end

   // ==========================================================
   // reference domain synchronisers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         chanMeta_q <= '0;
         chanSync_q <= '0;
         qualMeta_q <= 1'b0;
         qualSync_q <= 1'b0;
         reqMeta_q  <= 1'b0;
         reqSync_q  <= 1'b0;
         ackT_q     <= 1'b0;
      end else if (ce) begin
         chanMeta_q <= chanPin;                             // see RULE_01
         chanSync_q <= chanMeta_q;
         qualMeta_q <= qualPin;
         qualSync_q <= qualMeta_q;
         reqMeta_q  <= reqT_q;
         reqSync_q  <= reqMeta_q;
         ackT_q     <= reqSync_q;
      end
   end

   // ==========================================================
   // sample source selection and qualifier gate
   always_comb begin
      if (syncMode_q) begin
         sampleValid = reqSync_q != ackT_q;                 // see RULE_02
         sampleWord  = held_q[NC-1:0];
         sampleQual  = held_q[NC];
      end else begin
         sampleValid = divCnt_q == 16'h0000;                // see RULE_03
         sampleWord  = chanSync_q;                          // see RULE_05
         sampleQual  = qualSync_q;
      end
      if (!qualEn_q) begin
         sampleQual = 1'b1;
      end
   end

   assign running = state_q == lacq_pkg::ST_FILL || state_q == lacq_pkg::ST_POST;
   assign memWe   = ce && running && sampleValid && sampleQual; // see RULE_08

   // internal sample rate divider
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         divCnt_q <= lacq_pkg::RATE_RST;
      end else if (ce) begin
         if (startReq || divCnt_q == 16'h0000) begin
            divCnt_q <= rate_q;                             // see RULE_03
         end else begin
            divCnt_q <= divCnt_q - 16'h0001;
         end
      end
   end

   // ==========================================================
   // trigger recognition
   assign mif.cur  = sampleWord;
   assign mif.prev = prevWord_q;
   assign mif.cond = pat_q;

   lacq_matcher u_matcher (
      .m (mif.matcher)
   );

   assign trigger = memWe && state_q == lacq_pkg::ST_FILL && mif.hit
                    && sampleCnt_q != 16'h0000 && sampleCnt_q >= cycles_q; // see RULE_11

   always_comb begin
      unique case (fill_q)
         lacq_pkg::FILL_PRE:  postTarget = lacq_pkg::POST_PRE;    // see RULE_07
         lacq_pkg::FILL_POST: postTarget = lacq_pkg::POST_POST;
         lacq_pkg::FILL_MID:  postTarget = lacq_pkg::POST_MID;
         default:             postTarget = postFill_q;
      endcase
   end

   // ==========================================================
   // acquisition sequencing
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= lacq_pkg::ST_IDLE;
      end else if (stopReq) begin
         state_q <= lacq_pkg::ST_IDLE;
      end else if (startReq) begin
         state_q <= lacq_pkg::ST_FILL;
      end else if (trigger) begin
         state_q <= postTarget == 16'h0000 ? lacq_pkg::ST_DONE : lacq_pkg::ST_POST;
      end else if (memWe && state_q == lacq_pkg::ST_POST && postCnt_q + 16'h0001 == postTarget) begin
         state_q <= lacq_pkg::ST_DONE;                      // see RULE_15
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         postCnt_q <= 16'h0000;
      end else if (trigger) begin
         postCnt_q <= 16'h0000;
      end else if (memWe && state_q == lacq_pkg::ST_POST) begin
         postCnt_q <= postCnt_q + 16'h0001;                 // see RULE_15
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         trigAddr_q <= '0;
      end else if (trigger) begin
         trigAddr_q <= wrPtr_q;                             // see RULE_16
      end
   end

   // ==========================================================
   // ring write pointer and sample history
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wrPtr_q     <= '0;
         wrap_q      <= 1'b0;
         sampleCnt_q <= 16'h0000;
         prevWord_q  <= '0;
      end else if (startReq) begin
         wrPtr_q     <= '0;
         wrap_q      <= 1'b0;
         sampleCnt_q <= 16'h0000;
      end else if (memWe) begin
         wrPtr_q    <= wrPtr_q + 1'b1;                      // see RULE_06
         prevWord_q <= sampleWord;
         if (&wrPtr_q) begin
            wrap_q <= 1'b1;
         end
         if (sampleCnt_q != 16'hFFFF) begin
            sampleCnt_q <= sampleCnt_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (memWe) begin
         mem[wrPtr_q] <= sampleWord;                        // see RULE_06
      end
   end

   // ==========================================================
   // download port
   always_ff @(posedge ref_clk) begin
      if (ce) begin
         rdData_q <= mem[rdAddr_q];                         // see RULE_12
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdAddr_q <= '0;
      end else if (wrEn && pendAddr_q == lacq_pkg::REG_RD_ADDR) begin
         rdAddr_q <= hwdata[AW-1:0];
      end else if (rdDone && pendAddr_q == lacq_pkg::REG_RD_DATA) begin
         rdAddr_q <= rdAddr_q + 1'b1;                       // see RULE_12
      end
   end

   // ==========================================================
   // checks
   qual_gate_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_08
      memWe |-> sampleQual)
      else $error("sample stored while qualifier false");

   ring_advance_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_06
      memWe && !startReq |=> wrPtr_q == AW'($past(wrPtr_q) + 1'b1))
      else $error("write pointer did not advance by one");

   trig_addr_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_16
      trigger |=> trigAddr_q == $past(wrPtr_q))
      else $error("trigger address not recorded");

   post_end_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_15
      memWe && !stopReq && !startReq && state_q == lacq_pkg::ST_POST && postCnt_q + 16'h0001 == postTarget
      |=> state_q == lacq_pkg::ST_DONE)
      else $error("acquisition did not end at post fill count");

   done_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_15
      state_q == lacq_pkg::ST_DONE |-> !memWe)
      else $error("sample stored after acquisition ended");

   dont_care_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_09
      mif.cond == '0 |-> mif.hit)
      else $error("all don't-care pattern did not match");

   rise_edge_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_10
      mif.hit && mif.cond[lacq_pkg::COND_W-1:0] == lacq_pkg::COND_RISE |-> mif.cur[0] && !mif.prev[0])
      else $error("rising edge condition matched without a rise");

   async_tick_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_03
      memWe && !syncMode_q |-> divCnt_q == 16'h0000)
      else $error("internal sample taken off the rate tick");

   sync_tick_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_04
      memWe && syncMode_q |-> reqSync_q != ackT_q ##1 reqSync_q == ackT_q)
      else $error("external sample not tied to a captured edge");

   bus_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
      accept && ce && !pend_q ##1 ce |-> !hreadyout ##1 hreadyout)
      else $error("bus transfer wait state wrong");

   download_step_a: assert property (@(posedge ref_clk) disable iff (rst) // see RULE_12
      rdDone && pendAddr_q == lacq_pkg::REG_RD_DATA |=> rdAddr_q == AW'($past(rdAddr_q) + 1'b1))
      else $error("read address did not step after data read");

endmodule // lacq_acquisition
`default_nettype wire

// *** core/lacq_pkg.sv ***
package lacq_pkg;
   // ==========================================================
   // sizes
   localparam int NUM_CHAN = 18;
   localparam int ADDR_W   = 16;
   localparam int DEPTH    = 65536;
   localparam int COND_W   = 3;
   localparam int PAT_W    = NUM_CHAN * COND_W;
   localparam int PAT_LO_W = 30;
   localparam int PAT_HI_W = PAT_W - PAT_LO_W;

   // ==========================================================
   // per-channel pattern condition and trigger position choice
   typedef enum logic [COND_W-1:0] {
      COND_DONT_CARE, COND_LOW, COND_HIGH, COND_RISE, COND_FALL, COND_EITHER
   } lacq_cond_type;
   typedef enum logic [1:0] {FILL_PRE, FILL_POST, FILL_MID, FILL_CUSTOM} lacq_fill_type;
   typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_POST, ST_DONE} lacq_state_type;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_STATUS    = 8'h04;
   localparam logic [7:0] REG_RATE      = 8'h08;
   localparam logic [7:0] REG_POSTFILL  = 8'h0C;
   localparam logic [7:0] REG_PAT_LO    = 8'h10;
   localparam logic [7:0] REG_PAT_HI    = 8'h14;
   localparam logic [7:0] REG_CYCLES    = 8'h18;
   localparam logic [7:0] REG_TRIG_ADDR = 8'h1C;
   localparam logic [7:0] REG_WR_PTR    = 8'h20;
   localparam logic [7:0] REG_RD_ADDR   = 8'h24;
   localparam logic [7:0] REG_RD_DATA   = 8'h28;

   // ==========================================================
   // field positions
   localparam int CTRL_START    = 0;
   localparam int CTRL_STOP     = 1;
   localparam int CTRL_SYNC     = 2;
   localparam int CTRL_QUAL_EN  = 3;
   localparam int CTRL_FILL_LSB = 4;
   localparam int STAT_RUN      = 0;
   localparam int STAT_POST     = 1;
   localparam int STAT_DONE     = 2;
   localparam int STAT_WRAP     = 3;
   localparam int HTRANS_ACTIVE = 1;

   // ==========================================================
   // reset values and post-trigger fill counts
   localparam logic [15:0] RATE_RST     = 16'h0000;
   localparam logic [15:0] POSTFILL_RST = 16'h0000;
   localparam logic [15:0] CYCLES_RST   = 16'h0000;
   localparam logic [15:0] POST_PRE     = 16'h0000;
   localparam logic [15:0] POST_MID     = 16'h7FFF;
   localparam logic [15:0] POST_POST    = 16'hFFFF;
endpackage

// *** core/lacq_match_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface lacq_match_if;
   logic [lacq_pkg::NUM_CHAN-1:0] cur;
   logic [lacq_pkg::NUM_CHAN-1:0] prev;
   logic [lacq_pkg::PAT_W-1:0]    cond;
   logic                          hit;
   modport engine  (output cur, output prev, output cond, input hit);
   modport matcher (input cur, input prev, input cond, output hit);
endinterface
`default_nettype wire

// *** core/lacq_matcher.sv ***
`timescale 1ns/1ps
`default_nettype none
module lacq_matcher (
   lacq_match_if.matcher m
);
   logic [lacq_pkg::NUM_CHAN-1:0] chanOk;

   // ==========================================================
   // per-channel condition check
   genvar i;
   for (i = 0; i < lacq_pkg::NUM_CHAN; i++) begin : g_chan
      logic [lacq_pkg::COND_W-1:0] c;
      logic                        ok;
      assign c = m.cond[i*lacq_pkg::COND_W +: lacq_pkg::COND_W];
      always_comb begin
         unique case (c)
            lacq_pkg::COND_DONT_CARE: ok = 1'b1;                         // see RULE_09
            lacq_pkg::COND_LOW:       ok = !m.cur[i];                    // see RULE_14
            lacq_pkg::COND_HIGH:      ok = m.cur[i];                     // see RULE_14
            lacq_pkg::COND_RISE:      ok = m.cur[i] && !m.prev[i];       // see RULE_10
            lacq_pkg::COND_FALL:      ok = !m.cur[i] && m.prev[i];       // see RULE_10
            lacq_pkg::COND_EITHER:    ok = m.cur[i] != m.prev[i];        // see RULE_14
            default:                  ok = 1'b0;
         endcase
      end
      assign chanOk[i] = ok;
   end

   // combination across all channels
   assign m.hit = &chanOk; // see RULE_11
endmodule // lacq_matcher
`default_nettype wire

// *** testbench/lacq_target_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// target board: slow counter on the channels, clock only while running
module lacq_target_model (
   input  wire logic        run,
   output var  logic        extClk,
   output var  logic [17:0] chanPin,
   output wire logic        qualPin
);
   int n;
   initial begin
      extClk  = 1'b0;
      chanPin = 18'h20001;
      n       = 0;
      #7;
      forever begin
         if (run) begin
            #32 extClk = 1'b1;
            #32 extClk = 1'b0;
            n = n + 1;
            if (n % 8 == 0) chanPin = chanPin + 18'h00001;
         end else #8;
      end
   end
   assign qualPin = chanPin[2]; // qualifier follows channel 2
endmodule // lacq_target_model
`default_nettype wire

// *** testbench/logic_analyzer_acquisition_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module logic_analyzer_acquisition_tb_top;
   logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, run = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v, t, w;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [53:0] p;
   logic [17:0] chanPin;
   logic        extClk, qualPin, hreadyout, hresp;
   int          mismatches = 0, tests_run = 0;
   always #20 ref_clk = ~ref_clk;
   lacq_target_model u_tgt (.run(run), .extClk(extClk), .chanPin(chanPin), .qualPin(qualPin));
   lacq_acquisition u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .extClk(extClk), .chanPin(chanPin),
      .qualPin(qualPin), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
   // ==========================================================
   // bus cycles and comparison
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic set_pat(input logic [53:0] q);
      wr(lacq_pkg::REG_PAT_LO, {2'h0, q[29:0]});
      wr(lacq_pkg::REG_PAT_HI, {8'h00, q[53:30]});
   endtask
   task automatic wait_done;
      do ahb(1'b0, lacq_pkg::REG_STATUS, 32'h0, v); while (v[lacq_pkg::STAT_DONE] !== 1'b1);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic test_reset;
      ahb(1'b0, lacq_pkg::REG_RATE, 32'h0, v); check("rate", v, 32'h0);
      ahb(1'b0, lacq_pkg::REG_POSTFILL, 32'h0, v); check("postfill", v, 32'h0);
      ahb(1'b0, lacq_pkg::REG_STATUS, 32'h0, v); check("status", v, 32'h0);
      ahb(1'b0, 8'h3C, 32'h0, v); check("unmapped", v, 32'h0);
      check("hresp", {31'h0, hresp}, 32'h0);
      $display("test reset done");
   endtask
   task automatic test_stop;
      set_pat({51'h0, 3'h6}); // never-matching code
      wr(lacq_pkg::REG_CTRL, 32'h25); // sync, mid fill, start, no link clock
      ahb(1'b0, lacq_pkg::REG_STATUS, 32'h0, v); check("running", v, 32'h1);
      ahb(1'b0, lacq_pkg::REG_CTRL, 32'h0, v); check("ctrl", v, 32'h24);
      wr(lacq_pkg::REG_CTRL, 32'h2);
      ahb(1'b0, lacq_pkg::REG_STATUS, 32'h0, v); check("stopped", v, 32'h0);
      $display("test stop done");
   endtask
   task automatic test_async_level;
      p = '0;
      p[2:0]   = lacq_pkg::COND_HIGH;
      p[5:3]   = lacq_pkg::COND_LOW;
      p[53:51] = lacq_pkg::COND_HIGH;
      set_pat(p);
      wr(lacq_pkg::REG_RATE, 32'h2);
      wr(lacq_pkg::REG_POSTFILL, 32'h3);
      wr(lacq_pkg::REG_CTRL, 32'h31); // custom fill, start
      wait_done;
      ahb(1'b0, lacq_pkg::REG_TRIG_ADDR, 32'h0, t);
      ahb(1'b0, lacq_pkg::REG_WR_PTR, 32'h0, w);
      check("postfill end", {16'h0, w[15:0]}, {16'h0, t[15:0] + 16'h0004});
      wr(lacq_pkg::REG_RD_ADDR, t);
      ahb(1'b0, lacq_pkg::REG_RD_DATA, 32'h0, v);
      check("trigger sample", {14'h0, v[17:0]}, 32'h20001);
      $display("test async level done");
   endtask
   task automatic test_sync_edges;
      logic [31:0] a;
      lacq_pkg::lacq_cond_type c [3];
      c = '{lacq_pkg::COND_RISE, lacq_pkg::COND_FALL, lacq_pkg::COND_EITHER};
      foreach (c[i]) begin
         set_pat({51'h0, c[i]});
         wr(lacq_pkg::REG_CYCLES, 32'h4);
         wr(lacq_pkg::REG_CTRL, 32'h0D); // sync, qualifier, pre fill, start
         run <= 1'b1;
         wait_done;
         run <= 1'b0;
         ahb(1'b0, lacq_pkg::REG_TRIG_ADDR, 32'h0, t);
         ahb(1'b0, lacq_pkg::REG_WR_PTR, 32'h0, w);
         check("pre fill end", {16'h0, w[15:0]}, {16'h0, t[15:0] + 16'h0001});
         wr(lacq_pkg::REG_RD_ADDR, {16'h0, t[15:0] - 16'h0001});
         ahb(1'b0, lacq_pkg::REG_RD_DATA, 32'h0, a);
         ahb(1'b0, lacq_pkg::REG_RD_DATA, 32'h0, v);
         check("qualified", {30'h0, a[2], v[2]}, 32'h3);
         if (i == 2) check("either edge", {31'h0, a[0] ^ v[0]}, 32'h1);
         else check("edge", {30'h0, a[0], v[0]}, (i == 0) ? 32'h1 : 32'h2);
      end
      $display("test sync edges done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      test_reset;
      test_stop;
      test_async_level;
      test_sync_edges;
      complete_run;
   end
   initial begin
      #2400000;
      mismatches++;
      complete_run;
   end
endmodule // logic_analyzer_acquisition_tb_top
`default_nettype wire
